// ==== mis_pkg.sv ====
// Constants for the message ID screening block: register indices,
// field positions, reset values and AXI4-Lite response codes.
// Assumes 8-bit registers, each on its own aligned 32-bit word.
package mis_pkg;

	// Register indices; byte address is four times the index
	localparam logic [5:0] MIS_IDX_REF_BASE = 6'h00;
	localparam logic [5:0] MIS_IDX_REF_9 = 6'h09;
	localparam logic [5:0] MIS_IDX_REF_11 = 6'h0b;
	localparam logic [5:0] MIS_IDX_REF_13 = 6'h0d;
	localparam logic [5:0] MIS_IDX_REF_15 = 6'h0f;
	localparam logic [5:0] MIS_IDX_REF_18 = 6'h12;
	localparam logic [5:0] MIS_IDX_START_POS = 6'h14;
	localparam logic [5:0] MIS_IDX_CTRL = 6'h15;
	localparam logic [5:0] MIS_IDX_STATUS = 6'h18;
	localparam int MIS_REF_COUNT = 20;
	localparam logic [5:0] MIS_REF_COUNT_IDX = 6'h14;

	// Control register fields
	localparam int MIS_CTRL_EN_BIT = 3;
	localparam int MIS_CTRL_ORG_BIT = 2;
	localparam int MIS_CTRL_NTS_LSB = 0;

	// Status register fields
	localparam int MIS_STAT_BUSY_BIT = 0;
	localparam int MIS_STAT_MATCH_BIT = 1;
	localparam int MIS_STAT_MISS_BIT = 2;
	localparam int MIS_STAT_IDX_LSB = 4;

	// Reset values
	localparam logic [7:0] MIS_REF_RESET = 8'h00;
	localparam logic [6:0] MIS_START_RESET = 7'h00;
	localparam logic [3:0] MIS_CTRL_RESET = 4'h0;

	// Reference ID layout
	localparam logic [9:0] MIS_IDS_2BYTE = 10'h3ff;
	localparam logic [9:0] MIS_IDS_4BYTE = 10'h01f;

	// AXI responses
	localparam logic [1:0] MIS_RESP_OKAY = 2'h0;
	localparam logic [1:0] MIS_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		MIS_IDLE,
		MIS_SKIP,
		MIS_COMPARE
	} mis_state_t;

endpackage

// ==== mis_axil.sv ====
// AXI4-Lite slave front end for the screening block.
// Assumes the parent decodes indices combinationally and answers
// wr_err, rd_data and rd_err in the same cycle as the request.
`timescale 1ns/100ps
module mis_axil import mis_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [7:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	output logic wr_en,
	output logic [5:0] wr_idx,
	output logic [7:0] wr_data,
	output logic wr_strb,
	input wire logic wr_err,
	output logic [5:0] rd_idx,
	input wire logic [7:0] rd_data,
	input wire logic rd_err
);

	logic aw_full_r, aw_full_nxt;
	logic w_full_r, w_full_nxt;
	logic [5:0] aw_idx_r, aw_idx_nxt;
	logic [7:0] w_data_r, w_data_nxt;
	logic w_strb_r, w_strb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic aw_take, w_take, ar_take;

	// Address and data may arrive in either order; hold until both
	assign s_axil_awready = !aw_full_r && !bvalid_r;
	assign s_axil_wready = !w_full_r && !bvalid_r;
	assign s_axil_arready = !rvalid_r;
	assign aw_take = s_axil_awvalid && s_axil_awready;
	assign w_take = s_axil_wvalid && s_axil_wready;
	assign ar_take = s_axil_arvalid && s_axil_arready;
	assign wr_en = aw_full_r && w_full_r;
	assign wr_idx = aw_idx_r;
	assign wr_data = w_data_r;
	assign wr_strb = w_strb_r;
	assign rd_idx = s_axil_araddr[7:2];
	assign s_axil_bvalid = bvalid_r;
	assign s_axil_bresp = bresp_r;
	assign s_axil_rvalid = rvalid_r;
	assign s_axil_rdata = rdata_r;
	assign s_axil_rresp = rresp_r;

	// Channel state next values
	always_comb begin
		aw_full_nxt = wr_en ? 1'b0 : (aw_full_r || aw_take);
		w_full_nxt = wr_en ? 1'b0 : (w_full_r || w_take);
		aw_idx_nxt = aw_take ? s_axil_awaddr[7:2] : aw_idx_r;
		w_data_nxt = w_take ? s_axil_wdata[7:0] : w_data_r;
		w_strb_nxt = w_take ? s_axil_wstrb[0] : w_strb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (wr_en) begin
			bvalid_nxt = 1'b1;
			bresp_nxt = wr_err ? MIS_RESP_SLVERR : MIS_RESP_OKAY;
		end else if (bvalid_r && s_axil_bready) begin
			bvalid_nxt = 1'b0;
		end
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (ar_take) begin
			rvalid_nxt = 1'b1;
			rdata_nxt = {24'h00_0000, rd_data}; // Upper bits read as zero
			rresp_nxt = rd_err ? MIS_RESP_SLVERR : MIS_RESP_OKAY;
		end else if (rvalid_r && s_axil_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	// Channel state registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_idx_r <= 6'h00;
			w_data_r <= 8'h00;
			w_strb_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= MIS_RESP_OKAY;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= MIS_RESP_OKAY;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			aw_idx_r <= aw_idx_nxt;
			w_data_r <= w_data_nxt;
			w_strb_r <= w_strb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
		end
	end

endmodule

// ==== mis_screen.sv ====
// Message ID screening: compares payload bits after frame sync with
// software-written reference ID bytes, registers over AXI4-Lite.
// Assumes frame_sync_found and rx_bit_valid are one-cycle strobes from
// the receiver's data recovery logic, synchronous to aclk.
//
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/100ps

// Contract
// - Screening compares only while the enable bit is 1; enable resets to 0.
// - Organisation bit 0 gives 2-byte IDs, 1 gives 4-byte IDs; resets 0.
// - In 4-byte mode the scan field 00..11 scans 1..4 bytes.
// - In 2-byte mode field 00 scans one byte, other values two.
// - Seven-bit start field: 0 starts one bit after sync, 7F 128 bits.
// - Twenty writable 8-bit reference bytes, all cleared by reset.
module mis_screen import mis_pkg::*; (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axil_awaddr,
	input wire logic s_axil_awvalid,
	output logic s_axil_awready,
	input wire logic [31:0] s_axil_wdata,
	input wire logic [3:0] s_axil_wstrb,
	input wire logic s_axil_wvalid,
	output logic s_axil_wready,
	output logic [1:0] s_axil_bresp,
	output logic s_axil_bvalid,
	input wire logic s_axil_bready,
	input wire logic [7:0] s_axil_araddr,
	input wire logic s_axil_arvalid,
	output logic s_axil_arready,
	output logic [31:0] s_axil_rdata,
	output logic [1:0] s_axil_rresp,
	output logic s_axil_rvalid,
	input wire logic s_axil_rready,
	input wire logic frame_sync_found,
	input wire logic rx_bit_valid,
	input wire logic rx_bit,
	output logic id_match,
	output logic id_mismatch,
	output logic scan_busy,
	output logic [3:0] match_id_index
);

	logic wr_en;
	logic [5:0] wr_idx;
	logic [7:0] wr_data;
	logic wr_strb;
	logic wr_err;
	logic [5:0] rd_idx;
	logic [7:0] rd_data;
	logic rd_err;

	// Register file state
	logic [7:0] ref_r [MIS_REF_COUNT];
	logic [7:0] ref_nxt [MIS_REF_COUNT];
	logic [6:0] start_pos_r, start_pos_nxt;
	logic [3:0] ctrl_r, ctrl_nxt;
	logic stat_match_r, stat_match_nxt;
	logic stat_miss_r, stat_miss_nxt;

	// Scan engine state
	mis_state_t state_r, state_nxt;
	logic [6:0] skip_cnt_r, skip_cnt_nxt;
	logic [4:0] pos_r, pos_nxt;
	logic [5:0] nbits_r, nbits_nxt;
	logic org4_r, org4_nxt;
	logic [9:0] alive_r, alive_nxt;
	logic match_r, match_nxt;
	logic miss_r, miss_nxt;
	logic [3:0] idx_r, idx_nxt;

	logic screening_enable;
	logic id_byte_organisation;
	logic [1:0] bytes_to_scan;

	assign screening_enable = ctrl_r[MIS_CTRL_EN_BIT];
	assign id_byte_organisation = ctrl_r[MIS_CTRL_ORG_BIT];
	assign bytes_to_scan = ctrl_r[MIS_CTRL_NTS_LSB +: 2];

	// Number of bits to scan for a given organisation and scan field
	function automatic logic [5:0] scan_bits(input logic org4, input logic [1:0] nts);
		logic [2:0] nbytes;
		nbytes = 3'd1;
		if (org4) begin
			nbytes = {1'b0, nts} + 3'd1;
		end else if (nts != 2'b00) begin
			nbytes = 3'd2;
		end
		return {nbytes, 3'b000};
	endfunction

	// Reference bit for ID slot k at scan bit position pos, MSB first
	function automatic logic ref_bit(input logic org4, input logic [3:0] k,
			input logic [4:0] pos, input logic [7:0] refs [MIS_REF_COUNT]);
		logic [5:0] idx;
		idx = org4 ? {k, 2'b00} + {4'h0, pos[4:3]} : {1'b0, k, 1'b0} + {5'h00, pos[3]};
		if (idx >= MIS_REF_COUNT_IDX) begin
			return 1'b0;
		end
		return refs[idx[4:0]][3'd7 - pos[2:0]];
	endfunction

	// Lowest ID slot still matching
	function automatic logic [3:0] first_set(input logic [9:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 9; i >= 0; i--) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction

	// Bus front end
	mis_axil u_axil (
		.aclk(aclk),
		.aresetn(aresetn),
		.s_axil_awaddr(s_axil_awaddr),
		.s_axil_awvalid(s_axil_awvalid),
		.s_axil_awready(s_axil_awready),
		.s_axil_wdata(s_axil_wdata),
		.s_axil_wstrb(s_axil_wstrb),
		.s_axil_wvalid(s_axil_wvalid),
		.s_axil_wready(s_axil_wready),
		.s_axil_bresp(s_axil_bresp),
		.s_axil_bvalid(s_axil_bvalid),
		.s_axil_bready(s_axil_bready),
		.s_axil_araddr(s_axil_araddr),
		.s_axil_arvalid(s_axil_arvalid),
		.s_axil_arready(s_axil_arready),
		.s_axil_rdata(s_axil_rdata),
		.s_axil_rresp(s_axil_rresp),
		.s_axil_rvalid(s_axil_rvalid),
		.s_axil_rready(s_axil_rready),
		.wr_en(wr_en),
		.wr_idx(wr_idx),
		.wr_data(wr_data),
		.wr_strb(wr_strb),
		.wr_err(wr_err),
		.rd_idx(rd_idx),
		.rd_data(rd_data),
		.rd_err(rd_err)
	);

	// Write decode; unmapped indices answer SLVERR and store nothing
	assign wr_err = !(wr_idx < MIS_REF_COUNT_IDX || wr_idx == MIS_IDX_START_POS ||
		wr_idx == MIS_IDX_CTRL || wr_idx == MIS_IDX_STATUS);

	// Read decode
	always_comb begin
		rd_data = 8'h00;
		rd_err = 1'b0;
		if (rd_idx < MIS_REF_COUNT_IDX) begin
			rd_data = ref_r[rd_idx[4:0]];
		end else if (rd_idx == MIS_IDX_START_POS) begin
			rd_data = {1'b0, start_pos_r};
		end else if (rd_idx == MIS_IDX_CTRL) begin
			rd_data = {4'h0, ctrl_r};
		end else if (rd_idx == MIS_IDX_STATUS) begin
			rd_data[MIS_STAT_BUSY_BIT] = (state_r != MIS_IDLE);
			rd_data[MIS_STAT_MATCH_BIT] = stat_match_r;
			rd_data[MIS_STAT_MISS_BIT] = stat_miss_r;
			rd_data[MIS_STAT_IDX_LSB +: 4] = idx_r;
		end else begin
			rd_err = 1'b1;
		end
	end

	// Register file next values; a new result beats a same-cycle clear
	always_comb begin
		ref_nxt = ref_r;
		start_pos_nxt = start_pos_r;
		ctrl_nxt = ctrl_r;
		stat_match_nxt = stat_match_r || match_r;
		stat_miss_nxt = stat_miss_r || miss_r;
		if (wr_en && wr_strb) begin
			if (wr_idx < MIS_REF_COUNT_IDX) begin
				ref_nxt[wr_idx[4:0]] = wr_data;
			end else if (wr_idx == MIS_IDX_START_POS) begin
				start_pos_nxt = wr_data[6:0];
			end else if (wr_idx == MIS_IDX_CTRL) begin
				ctrl_nxt = wr_data[3:0];
			end else if (wr_idx == MIS_IDX_STATUS) begin
				stat_match_nxt = (stat_match_r && !wr_data[MIS_STAT_MATCH_BIT]) || match_r;
				stat_miss_nxt = (stat_miss_r && !wr_data[MIS_STAT_MISS_BIT]) || miss_r;
			end
		end
	end

	// Register file; everything clears on reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < MIS_REF_COUNT; i++) begin
				ref_r[i] <= MIS_REF_RESET;
			end
			start_pos_r <= MIS_START_RESET;
			ctrl_r <= MIS_CTRL_RESET;
			stat_match_r <= 1'b0;
			stat_miss_r <= 1'b0;
		end else begin
			ref_r <= ref_nxt;
			start_pos_r <= start_pos_nxt;
			ctrl_r <= ctrl_nxt;
			stat_match_r <= stat_match_nxt;
			stat_miss_r <= stat_miss_nxt;
		end
	end

	// Scan engine. Organisation, scan count and start are latched at sync; reference bytes are
	// read live, so a mid-frame reference write changes the frame in flight; clearing enable aborts at once.
	always_comb begin
		state_nxt = state_r;
		skip_cnt_nxt = skip_cnt_r;
		pos_nxt = pos_r;
		nbits_nxt = nbits_r;
		org4_nxt = org4_r;
		alive_nxt = alive_r;
		match_nxt = 1'b0;
		miss_nxt = 1'b0;
		idx_nxt = idx_r;
		if (!screening_enable) begin
			state_nxt = MIS_IDLE;
			alive_nxt = 10'h000;
		end else if (frame_sync_found) begin
			// Sync restarts the scan; the sync bit itself is not counted
			org4_nxt = id_byte_organisation;
			nbits_nxt = scan_bits(id_byte_organisation, bytes_to_scan);
			alive_nxt = id_byte_organisation ? MIS_IDS_4BYTE : MIS_IDS_2BYTE;
			pos_nxt = 5'h00;
			skip_cnt_nxt = start_pos_r;
			state_nxt = (start_pos_r == 7'h00) ? MIS_COMPARE : MIS_SKIP;
		end else begin
			case (state_r)
				MIS_SKIP: begin
					if (rx_bit_valid) begin
						skip_cnt_nxt = skip_cnt_r - 7'd1;
						if (skip_cnt_r == 7'd1) begin
							state_nxt = MIS_COMPARE;
						end
					end
				end
				MIS_COMPARE: begin
					if (rx_bit_valid) begin
						for (int k = 0; k < 10; k++) begin
							alive_nxt[k] = alive_r[k] &&
								(rx_bit == ref_bit(org4_r, 4'(k), pos_r, ref_r));
						end
						pos_nxt = pos_r + 5'd1;
						if ({1'b0, pos_r} == nbits_r - 6'd1) begin
							state_nxt = MIS_IDLE;
							if (alive_nxt != 10'h000) begin
								match_nxt = 1'b1;
								idx_nxt = first_set(alive_nxt);
							end else begin
								miss_nxt = 1'b1;
							end
						end
					end
				end
				default: begin
					state_nxt = MIS_IDLE;
				end
			endcase
		end
	end

	// Scan engine registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= MIS_IDLE;
			skip_cnt_r <= 7'h00;
			pos_r <= 5'h00;
			nbits_r <= 6'h00;
			org4_r <= 1'b0;
			alive_r <= 10'h000;
			match_r <= 1'b0;
			miss_r <= 1'b0;
			idx_r <= 4'h0;
		end else begin
			state_r <= state_nxt;
			skip_cnt_r <= skip_cnt_nxt;
			pos_r <= pos_nxt;
			nbits_r <= nbits_nxt;
			org4_r <= org4_nxt;
			alive_r <= alive_nxt;
			match_r <= match_nxt;
			miss_r <= miss_nxt;
			idx_r <= idx_nxt;
		end
	end

	// Result outputs from flops; scan_busy is decoded from state_r
	assign id_match = match_r;
	assign id_mismatch = miss_r;
	assign scan_busy = (state_r != MIS_IDLE);
	assign match_id_index = idx_r;

endmodule

// ==== mis_screen_assertions.sv ====
// Checker on the mis_screen ports, bound to every instance.
// Enable state is internal, so scan rules lean on bit counts.
`timescale 1ns/100ps
module mis_screen_assertions (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axil_arvalid,
	input wire logic s_axil_arready,
	input wire logic s_axil_rvalid,
	input wire logic frame_sync_found,
	input wire logic rx_bit_valid,
	input wire logic id_match,
	input wire logic id_mismatch,
	input wire logic scan_busy,
	input wire logic [3:0] match_id_index
);
	logic [7:0] nbit_r;
	logic [7:0] nbit_nxt;
	logic done;
	assign done = id_match || id_mismatch;
	// Bits since last sync; saturates so idle traffic cannot wrap
	always_comb begin
		nbit_nxt = nbit_r;
		if (frame_sync_found) nbit_nxt = 8'h00;
		else if (rx_bit_valid && nbit_r != 8'hff) nbit_nxt = nbit_r + 8'h01;
	end
	always_ff @(posedge aclk) nbit_r <= aresetn ? nbit_nxt : 8'hff;
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	chk_result_excl: assert property (!(id_match && id_mismatch))
		else $error("match and mismatch together");
	chk_match_pulse: assert property (id_match |=> !id_match)
		else $error("match pulse too long");
	chk_result_busy: assert property (done |-> !scan_busy && $past(scan_busy))
		else $error("result without a scan");
	chk_result_bit: assert property (done |-> $past(rx_bit_valid))
		else $error("result not after a bit");
	chk_busy_start: assert property (!scan_busy && !frame_sync_found |=> !scan_busy)
		else $error("scan began without sync");
	chk_scan_len: assert property (done |-> nbit_r >= 8'h08 && nbit_r <= 8'h9f)
		else $error("scan length out of range");
	chk_index_hold: assert property ($changed(match_id_index) |-> id_match)
		else $error("index moved without match");
	chk_read_lat: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
		else $error("read answer late");
endmodule
bind mis_screen mis_screen_assertions u_chk (.aclk, .aresetn, .s_axil_arvalid,
	.s_axil_arready, .s_axil_rvalid, .frame_sync_found, .rx_bit_valid, .id_match,
	.id_mismatch, .scan_busy, .match_id_index);

// ==== mis_rx_model.sv ====
// Receiver model: sync pulse, then serial bits with random gaps.
// Between valid bits of a frame the data line shows the inverse of the last bit.
`timescale 1ns/100ps
module mis_rx_model (
	input wire logic aclk,
	output logic frame_sync_found,
	output logic rx_bit_valid,
	output logic rx_bit
);
	initial begin
		frame_sync_found = 1'h0;
		rx_bit_valid = 1'h0;
		rx_bit = 1'h0;
	end
	// Filler s bits, then nb bytes of p MSB first; gap caps idle cycles
	task automatic send(input int s, input int nb, input logic [31:0] p, input int gap);
		int i, g;
		frame_sync_found <= 1'h1;
		@(posedge aclk);
		frame_sync_found <= 1'h0;
		for (i = 0; i < s + nb * 8; i++) begin
			rx_bit_valid <= 1'h1;
			rx_bit <= (i < s) ? 1'($urandom) : p[31 - i + s];
			@(posedge aclk);
			g = $urandom % (gap + 1);
			if (g > 0) begin
				rx_bit_valid <= 1'h0;
				rx_bit <= ~rx_bit;
				repeat (g) @(posedge aclk);
			end
		end
		rx_bit_valid <= 1'h0;
		rx_bit <= ~rx_bit;
	endtask
endmodule

// ==== mis_screen_tb.sv ====
// Bench for mis_screen: AXI4-Lite master, receiver model and a
// bench-side reference of the scan result. One clock, sync reset.
`timescale 1ns/100ps
module mis_screen_tb import mis_pkg::*; ;
	logic aclk = 1'h0;
	logic aresetn = 1'h0;
	logic awv = 1'h0, wv = 1'h0, arv = 1'h0;
	logic [7:0] awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0000_0000;
	logic [3:0] ws = 4'hf;
	logic [3:0] last_idx = 4'h0;
	logic awr, wrr, bvl, arr, rvl, fs, bval, bt, hit, miss, busy;
	logic [1:0] brs, rrs;
	logic [31:0] rdt;
	logic [3:0] hidx;
	logic [7:0] refs [20];
	int num_errors = 0, total_checks = 0, n_m = 0, n_x = 0;
	// Free-running clock
	always #2 aclk = ~aclk;
	mis_screen DUT (.aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awa), .s_axil_awvalid(awv),
		.s_axil_awready(awr), .s_axil_wdata(wd), .s_axil_wstrb(ws), .s_axil_wvalid(wv),
		.s_axil_wready(wrr), .s_axil_bresp(brs), .s_axil_bvalid(bvl), .s_axil_bready(1'h1),
		.s_axil_araddr(ara), .s_axil_arvalid(arv), .s_axil_arready(arr), .s_axil_rdata(rdt),
		.s_axil_rresp(rrs), .s_axil_rvalid(rvl), .s_axil_rready(1'h1),
		.frame_sync_found(fs), .rx_bit_valid(bval), .rx_bit(bt), .id_match(hit),
		.id_mismatch(miss), .scan_busy(busy), .match_id_index(hidx));
	mis_rx_model rx (.aclk(aclk), .frame_sync_found(fs), .rx_bit_valid(bval), .rx_bit(bt));
	task automatic ck(input logic [31:0] g, input logic [31:0] e, input string m);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("FAIL %0t %s: got %h exp %h", $time, m, g, e);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Write with both channels offered together; bready stays high
	task automatic wr(input logic [5:0] i, input logic [7:0] d, input logic [1:0] er);
		awa <= {i, 2'h0};
		wd <= {24'h00_0000, d};
		awv <= 1'h1;
		wv <= 1'h1;
		do begin
			@(posedge aclk);
			if (awr) awv <= 1'h0;
			if (wrr) wv <= 1'h0;
		end while (awv || wv);
		do @(posedge aclk); while (bvl !== 1'h1);
		ck(brs, er, "bresp");
	endtask
	task automatic rc(input logic [5:0] i, input logic [7:0] e, input logic [1:0] er);
		ara <= {i, 2'h0};
		arv <= 1'h1;
		do @(posedge aclk); while (arr !== 1'h1);
		arv <= 1'h0;
		do @(posedge aclk); while (rvl !== 1'h1);
		ck(rdt, {24'h00_0000, e}, "rdata");
		ck(rrs, er, "rresp");
	endtask
	function automatic int nbytes(input int o, input int n);
		return o ? n + 1 : (n == 0 ? 1 : 2);
	endfunction
	// Lowest slot whose scanned bytes all equal the payload
	function automatic logic [4:0] hit_of(input int o, input int n, input logic [31:0] p);
		int k, j;
		logic ok;
		for (k = 0; k < (o ? 5 : 10); k++) begin
			ok = 1'h1;
			for (j = 0; j < nbytes(o, n); j++)
				if (refs[k * (o ? 4 : 2) + j] !== p[31 - 8 * j -: 8]) ok = 1'h0;
			if (ok) return {1'h1, 4'(k)};
		end
		return 5'h00;
	endfunction
	// Result pulses stand one cycle, so count them at every edge
	always @(posedge aclk) begin
		if (hit === 1'h1) n_m++;
		if (miss === 1'h1) n_x++;
	end
	task automatic frame(input int o, input int n, input int s, input logic [31:0] p,
		input logic en);
		int cm, cx;
		logic [4:0] e;
		e = en ? hit_of(o, n, p) : 5'h00;
		if (e[4]) last_idx = e[3:0];
		cm = n_m;
		cx = n_x;
		rx.send(s, nbytes(o, n), p, $urandom % 3);
		repeat (4) @(negedge aclk);
		ck(n_m - cm, e[4], "match pulses");
		ck(n_x - cx, en & !e[4], "mismatch pulses");
		if (e[4]) ck(hidx, e[3:0], "index");
		ck(busy, 1'h0, "busy");
		@(posedge aclk);
		// Sticky status holds this frame's result; write-one clears both bits
		rc(MIS_IDX_STATUS, {last_idx, 1'h0, en & !e[4], e[4], 1'h0}, MIS_RESP_OKAY);
		wr(MIS_IDX_STATUS, 8'h06, MIS_RESP_OKAY);
	endtask
	// Cuts a hang short
	initial begin
		repeat (50000) @(posedge aclk);
		num_errors++;
		stop_test();
	end
	initial begin
		int i, o, n, t, s, k;
		logic [31:0] p;
		void'($urandom(32'habdb));
		repeat (20) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		// Reset values, unmapped index, reserved control bits
		for (i = 0; i < 22; i++) rc(6'(i), 8'h00, MIS_RESP_OKAY);
		rc(6'h1f, 8'h00, MIS_RESP_SLVERR);
		wr(6'h1f, 8'h5a, MIS_RESP_SLVERR);
		wr(MIS_IDX_CTRL, 8'hff, MIS_RESP_OKAY);
		rc(MIS_IDX_CTRL, 8'h0f, MIS_RESP_OKAY);
		// Byte 2 copies byte 0 so a one-byte scan in 2-byte mode hits two slots
		for (i = 0; i < 20; i++) begin
			refs[i] = (i == 2) ? refs[0] : 8'($urandom);
			wr(6'(i), refs[i], MIS_RESP_OKAY);
			rc(6'(i), refs[i], MIS_RESP_OKAY);
		end
		// No byte strobe: answered OKAY, nothing stored
		ws <= 4'h0;
		wr(6'h00, ~refs[0], MIS_RESP_OKAY);
		ws <= 4'hf;
		rc(6'h00, refs[0], MIS_RESP_OKAY);
		// Each mode and count: first offset, last offset, near miss
		for (o = 0; o < 2; o++)
			for (n = 0; n < 4; n++)
				for (t = 0; t < 3; t++) begin
					s = (t == 0) ? 0 : (t == 1) ? 127 : $urandom % 128;
					k = $urandom % (o ? 5 : 10);
					for (i = 0; i < 4; i++) p[31 - 8 * i -: 8] = refs[(k * (o ? 4 : 2) + i) % 20];
					if (t == 2) p[32 - 8 * nbytes(o, n)] ^= 1'h1;
					wr(MIS_IDX_START_POS, 8'(s), MIS_RESP_OKAY);
					wr(MIS_IDX_CTRL, 8'(8 + 4 * o + n), MIS_RESP_OKAY);
					frame(o, n, s, p, 1'h1);
				end
		// Disabled: a matching frame gives no result
		wr(MIS_IDX_CTRL, 8'h03, MIS_RESP_OKAY);
		frame(0, 3, 0, {refs[0], refs[1], 16'h0000}, 1'h0);
		// Mid-run reset must clear registers written above
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		@(posedge aclk);
		rc(MIS_IDX_CTRL, 8'h00, MIS_RESP_OKAY);
		rc(6'h01, 8'h00, MIS_RESP_OKAY);
		rc(MIS_IDX_START_POS, 8'h00, MIS_RESP_OKAY);
		stop_test();
	end
endmodule
